/* File: common/smp_pkg.sv */
`default_nettype none
package smp_pkg;
	localparam int SMP_NUM_PINS = 8;
	// Index of each input pin in the synchroniser vector
	localparam int SMP_PIN_FWD = 0;
	localparam int SMP_PIN_REV = 1;
	localparam int SMP_PIN_WIND_OFF = 2;
	localparam int SMP_PIN_FREE = 3;
	localparam int SMP_PIN_CLR = 4;
	localparam int SMP_PIN_CS = 5;
	localparam int SMP_PIN_FLT = 6;
	localparam int SMP_PIN_FATAL = 7;
	// Function switch bank positions
	localparam int SMP_SW_RANGE = 0;
	localparam int SMP_SW_FORMAT = 1;
	localparam int SMP_SW_SMOOTH = 2;
	localparam logic SMP_RANGE_ONE = 1'b0;
	localparam logic SMP_TWO_PULSE_FORMAT = 1'b0;
	localparam logic SMP_ONE_PULSE_FORMAT = 1'b1;
	localparam logic [3:0] SMP_SW_DEFAULT = 4'h0;
	localparam logic [3:0] SMP_ROTARY_DEFAULT = 4'h0;
	localparam logic [1:0] SMP_LOAD_WAIT = 2'h2;
	// Angles in units of 0.0000025 degree, so every step angle is whole
	localparam int SMP_POS_W = 22;
	localparam logic [SMP_POS_W-1:0] SMP_ORIGIN_PITCH = 22'h2BF200;
	localparam logic [SMP_POS_W-1:0] SMP_BASE_STEP = 22'h046500;
	localparam logic [SMP_POS_W-1:0] SMP_POS_ZERO = 22'h000000;
	localparam logic [SMP_POS_W-1:0] SMP_STEP_ONE [16] = '{
		22'h046500, 22'h023280, 22'h01C200, 22'h011940, 22'h00E100, 22'h008CA0, 22'h007080, 22'h003840,
		22'h002D00, 22'h001C20, 22'h001680, 22'h000E10, 22'h000B40, 22'h000900, 22'h0005A0, 22'h000480};
	localparam logic [SMP_POS_W-1:0] SMP_STEP_TWO [16] = '{
		22'h0AFC80, 22'h057E40, 22'h03A980, 22'h02BF20, 22'h01D4C0, 22'h015F90, 22'h00AFC8, 22'h005DC0,
		22'h0057E4, 22'h004E20, 22'h004650, 22'h002EE0, 22'h002BF2, 22'h002328, 22'h0015F9, 22'h0002D0};
	// Timing
	localparam int SMP_CLK_HZ = 25000000;
	localparam int SMP_BLINK_MS = 250;
	localparam int SMP_BLINK_CYC = SMP_CLK_HZ / 1000 * SMP_BLINK_MS;
	localparam int SMP_SMOOTH_US = 1000;
	localparam int SMP_SMOOTH_CYC = SMP_CLK_HZ / 1000000 * SMP_SMOOTH_US;
	localparam int SMP_GAP_W = 16;
	localparam int SMP_BLINK_W = 24;
	localparam int SMP_PEND_W = 8;
	typedef enum logic [1:0] {
		SMP_ST_LOAD = 2'b00,
		SMP_ST_RUN = 2'b01,
		SMP_ST_FAULT = 2'b10
	} smp_state_t;
endpackage : smp_pkg
`default_nettype wire

/* File: design/smp_step_io.sv */
`timescale 1ns/100ps
`default_nettype none
module smp_step_io
	import smp_pkg::*;
#(
	parameter int BLINK_CYC = SMP_BLINK_CYC,
	parameter int SMOOTH_CYC = SMP_SMOOTH_CYC
)(
	input wire logic clk,
	input wire logic nrst,
	input wire logic forward_step_in,
	input wire logic reverse_step_in,
	input wire logic winding_off_in,
	input wire logic free_run_in,
	input wire logic fault_clear_in,
	input wire logic step_size_in,
	input wire logic fault_event_in,
	input wire logic fault_fatal_in,
	input wire logic brake_fitted,
	input wire logic [3:0] function_switch_bank,
	input wire logic [3:0] rotary_step_switch,
	output logic motor_step,
	output logic motor_dir,
	output logic current_on,
	output logic brake_release,
	output logic phase_origin_out,
	output logic fault_out,
	output logic fault_led,
	output logic ready_out,
	output logic [SMP_POS_W-1:0] position
);
	// All levels here mean "optocoupler conducting"
	logic [SMP_NUM_PINS-1:0] pins;
	logic [SMP_NUM_PINS-1:0] sync_a;
	logic [SMP_NUM_PINS-1:0] sync_b;
	logic [SMP_NUM_PINS-1:0] sync_c;
	logic [3:0] sw_a;
	logic [3:0] sw_b;
	logic [3:0] rot_a;
	logic [3:0] rot_b;
	logic brk_a;
	logic brk_b;

	assign pins = {fault_fatal_in, fault_event_in, step_size_in, fault_clear_in,
		free_run_in, winding_off_in, reverse_step_in, forward_step_in};

	genvar gi;
	generate
		for (gi = 0; gi < SMP_NUM_PINS; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				if (!nrst) begin
					sync_a[gi] <= 1'b0;
					sync_b[gi] <= 1'b0;
					sync_c[gi] <= 1'b0;
				end else begin
					sync_a[gi] <= pins[gi];
					sync_b[gi] <= sync_a[gi];
					sync_c[gi] <= sync_b[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!nrst) begin
			sw_a <= SMP_SW_DEFAULT;
			sw_b <= SMP_SW_DEFAULT;
			rot_a <= SMP_ROTARY_DEFAULT;
			rot_b <= SMP_ROTARY_DEFAULT;
			brk_a <= 1'b0;
			brk_b <= 1'b0;
		end else begin
			sw_a <= function_switch_bank;
			sw_b <= sw_a;
			rot_a <= rotary_step_switch;
			rot_b <= rot_a;
			// Strap may be a jumper wired off-board, so it is synchronised like a pin
			brk_a <= brake_fitted;
			brk_b <= brk_a;
		end
	end

	function automatic logic rise(input int idx, input logic [SMP_NUM_PINS-1:0] now,
		input logic [SMP_NUM_PINS-1:0] prev);
		rise = now[idx] & ~prev[idx];
	endfunction : rise

	function automatic logic [SMP_POS_W-1:0] step_angle(input logic range_sel, input logic [3:0] dial);
		step_angle = (range_sel == SMP_RANGE_ONE) ? SMP_STEP_ONE[dial] : SMP_STEP_TWO[dial];
	endfunction : step_angle

	// Main state
	smp_state_t state;
	smp_state_t next_state;
	logic [1:0] load_cnt;
	logic [1:0] next_load_cnt;
	logic [3:0] cfg_sw;
	logic [3:0] next_cfg_sw;
	logic [3:0] cfg_rot;
	logic [3:0] next_cfg_rot;
	logic fatal_hold;
	logic next_fatal_hold;
	logic [SMP_POS_W-1:0] next_position;
	logic next_motor_step;
	logic next_motor_dir;
	logic [SMP_PEND_W-1:0] pend;
	logic [SMP_PEND_W-1:0] next_pend;
	logic pend_dir;
	logic next_pend_dir;
	logic [SMP_GAP_W-1:0] gap;
	logic [SMP_GAP_W-1:0] next_gap;
	logic [SMP_BLINK_W-1:0] blink_cnt;
	logic [SMP_BLINK_W-1:0] next_blink_cnt;
	logic next_fault_led;
	logic next_current_on;
	logic next_brake_release;
	logic next_ready_out;
	logic next_fault_out;
	logic next_phase_origin_out;

	logic wind_off;
	logic free;
	logic step_req;
	logic step_dir;
	logic [SMP_POS_W-1:0] angle;
	logic fire;
	logic fire_dir;

	always_comb begin
		wind_off = sync_b[SMP_PIN_WIND_OFF];
		free = sync_b[SMP_PIN_FREE];
		// Input format decides which pins mean step and direction
		if (cfg_sw[SMP_SW_FORMAT] == SMP_ONE_PULSE_FORMAT) begin
			step_req = rise(SMP_PIN_FWD, sync_b, sync_c);
			step_dir = sync_b[SMP_PIN_REV];
		end else begin
			step_req = rise(SMP_PIN_FWD, sync_b, sync_c) ^ rise(SMP_PIN_REV, sync_b, sync_c);
			step_dir = rise(SMP_PIN_REV, sync_b, sync_c);
		end
		// Step-size select forces the base angle
		angle = sync_b[SMP_PIN_CS] ? SMP_BASE_STEP : step_angle(cfg_sw[SMP_SW_RANGE], cfg_rot);
	end

	always_comb begin
		next_state = state;
		next_load_cnt = load_cnt;
		next_cfg_sw = cfg_sw;
		next_cfg_rot = cfg_rot;
		next_fatal_hold = fatal_hold;
		next_pend = pend;
		next_pend_dir = pend_dir;
		next_gap = gap;
		fire = 1'b0;
		fire_dir = step_dir;
		case (state)
			SMP_ST_LOAD: begin
				// Switches caught once after power-up, then frozen
				if (load_cnt == SMP_LOAD_WAIT) begin
					next_cfg_sw = sw_b;
					next_cfg_rot = rot_b;
					next_state = SMP_ST_RUN;
				end else begin
					next_load_cnt = load_cnt + 2'h1;
				end
			end
			SMP_ST_RUN: begin
				if (sync_b[SMP_PIN_FLT] || sync_b[SMP_PIN_FATAL]) begin
					next_state = SMP_ST_FAULT;
					next_fatal_hold = sync_b[SMP_PIN_FATAL];
					next_pend = '0;
				end else if (cfg_sw[SMP_SW_SMOOTH]) begin
					// Smoothing paces queued steps; a step in the other direction is dropped until the queue drains
					if (ready_out && step_req && (pend == '0 || pend_dir == step_dir) && pend != '1) begin
						next_pend = pend + 1'b1;
						next_pend_dir = step_dir;
					end
					if (gap != '0) begin
						next_gap = gap - 1'b1;
					end else if (pend != '0 && ready_out) begin
						fire = 1'b1;
						fire_dir = pend_dir;
						next_pend = next_pend - 1'b1;
						next_gap = SMP_GAP_W'(SMOOTH_CYC - 1);
					end
				end else begin
					fire = ready_out & step_req;
				end
			end
			SMP_ST_FAULT: begin
				// Only a rising reset edge clears, never a held level; fatal class stays
				// A cause still present at the clear edge wins over the clear
				if (rise(SMP_PIN_CLR, sync_b, sync_c) && !fatal_hold && !sync_b[SMP_PIN_FLT] &&
					!sync_b[SMP_PIN_FATAL]) begin
					next_state = SMP_ST_RUN;
				end
				if (sync_b[SMP_PIN_FATAL]) begin
					next_fatal_hold = 1'b1;
				end
			end
			default: begin
				next_state = SMP_ST_LOAD;
			end
		endcase
	end

	always_comb begin
		next_position = position;
		next_motor_step = fire;
		next_motor_dir = motor_dir;
		if (fire) begin
			next_motor_dir = fire_dir;
			// One configured angle per step, wrapping on the origin pitch
			if (!fire_dir) begin
				next_position = (position >= SMP_ORIGIN_PITCH - angle) ?
					position - (SMP_ORIGIN_PITCH - angle) : position + angle;
			end else begin
				next_position = (position >= angle) ?
					position - angle : position + (SMP_ORIGIN_PITCH - angle);
			end
		end
		next_phase_origin_out = (next_position == SMP_POS_ZERO);
		next_current_on = (next_state == SMP_ST_RUN) && !wind_off && !free;
		// Brake stays held under winding-off or alarm, released under free-run, which wins over both
		next_brake_release = brk_b && (free || next_current_on);
		next_ready_out = (next_state == SMP_ST_RUN) && !wind_off && !free &&
			(!brk_b || next_brake_release);
		next_fault_out = (next_state != SMP_ST_FAULT);
		if (next_state == SMP_ST_FAULT) begin
			if (blink_cnt == '0) begin
				next_blink_cnt = SMP_BLINK_W'(BLINK_CYC - 1);
				next_fault_led = ~fault_led;
			end else begin
				next_blink_cnt = blink_cnt - 1'b1;
				next_fault_led = fault_led;
			end
		end else begin
			next_blink_cnt = '0;
			next_fault_led = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state <= SMP_ST_LOAD;
			load_cnt <= 2'h0;
			cfg_sw <= SMP_SW_DEFAULT;
			cfg_rot <= SMP_ROTARY_DEFAULT;
			fatal_hold <= 1'b0;
			position <= SMP_POS_ZERO;
			motor_step <= 1'b0;
			motor_dir <= 1'b0;
			pend <= '0;
			pend_dir <= 1'b0;
			gap <= '0;
			blink_cnt <= '0;
			fault_led <= 1'b0;
			current_on <= 1'b0;
			brake_release <= 1'b0;
			ready_out <= 1'b0;
			fault_out <= 1'b1;
			phase_origin_out <= 1'b1;
		end else begin
			state <= next_state;
			load_cnt <= next_load_cnt;
			cfg_sw <= next_cfg_sw;
			cfg_rot <= next_cfg_rot;
			fatal_hold <= next_fatal_hold;
			position <= next_position;
			motor_step <= next_motor_step;
			motor_dir <= next_motor_dir;
			pend <= next_pend;
			pend_dir <= next_pend_dir;
			gap <= next_gap;
			blink_cnt <= next_blink_cnt;
			fault_led <= next_fault_led;
			current_on <= next_current_on;
			brake_release <= next_brake_release;
			ready_out <= next_ready_out;
			fault_out <= next_fault_out;
			phase_origin_out <= next_phase_origin_out;
		end
	end
endmodule : smp_step_io
`default_nettype wire

/* File: tb/smp_step_io_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module smp_step_io_sva
	import smp_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic winding_off_in,
	input wire logic free_run_in,
	input wire logic fault_clear_in,
	input wire logic fault_event_in,
	input wire logic fault_fatal_in,
	input wire logic brake_fitted,
	input wire logic motor_step,
	input wire logic current_on,
	input wire logic brake_release,
	input wire logic phase_origin_out,
	input wire logic fault_out,
	input wire logic ready_out,
	input wire logic [SMP_POS_W-1:0] position
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_quiet_clear;
		$stable(fault_clear_in) [*6];
	endsequence
	sequence s_inhibit;
		(winding_off_in || free_run_in) [*5];
	endsequence
	a_reset_home: assert property (disable iff (1'b0) !nrst |=> !ready_out && fault_out && phase_origin_out)
		else $error("outputs not at power-up state");
	a_origin_flag: assert property (phase_origin_out == (position == SMP_POS_ZERO))
		else $error("origin flag disagrees with position");
	a_step_single: assert property (motor_step |=> !motor_step)
		else $error("step pulse longer than one cycle");
	a_pos_only_step: assert property ($changed(position) |-> motor_step)
		else $error("position moved without a step");
	a_step_moves: assert property (motor_step |-> position != $past(position))
		else $error("step left position unchanged");
	a_ready_needs: assert property (ready_out |-> fault_out && current_on && (brake_release || !brake_fitted))
		else $error("ready while not all conditions hold");
	a_inhibit_cuts: assert property (s_inhibit |-> !current_on && !ready_out)
		else $error("current kept while inhibited");
	a_brake_held: assert property ((winding_off_in && !free_run_in) [*5] |-> !brake_release)
		else $error("brake released under winding off");
	a_free_brake: assert property ((free_run_in && brake_fitted) [*5] |-> brake_release)
		else $error("brake held under free run");
	a_alarm_cuts: assert property (!fault_out |-> !current_on && !ready_out)
		else $error("alarm without current cut");
	a_alarm_raise: assert property ((fault_event_in || fault_fatal_in) [*8] |-> !fault_out)
		else $error("alarm cause not reported");
	a_alarm_held: assert property (s_quiet_clear ##0 !fault_out |=> !fault_out)
		else $error("alarm cleared without reset edge");
	a_fatal_sticky: assert property (fault_fatal_in [*8] |=> !fault_out [*8])
		else $error("fatal alarm cleared");
endmodule : smp_step_io_sva
bind smp_step_io smp_step_io_sva u_sva(.clk(clk), .nrst(nrst), .winding_off_in(winding_off_in),
	.free_run_in(free_run_in), .fault_clear_in(fault_clear_in), .fault_event_in(fault_event_in),
	.fault_fatal_in(fault_fatal_in), .brake_fitted(brake_fitted), .motor_step(motor_step),
	.current_on(current_on), .brake_release(brake_release), .phase_origin_out(phase_origin_out),
	.fault_out(fault_out), .ready_out(ready_out), .position(position));
`default_nettype wire

/* File: tb/smp_ctl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module smp_ctl_model(
	input wire logic clk,
	input wire logic ready_out,
	output logic forward_step_in,
	output logic reverse_step_in
);
	initial begin
		forward_step_in = 1'b0;
		reverse_step_in = 1'b0;
	end
	// Pin held 4 cycles high and at least 3 low so every edge survives the synchroniser
	task automatic send(input int n, input logic rev, input logic one, input logic polite);
		if (one) reverse_step_in <= rev;
		for (int i = 0; i < n; i++) begin
			do @(posedge clk); while (polite && ready_out !== 1'b1);
			if (one || !rev) forward_step_in <= 1'b1;
			else reverse_step_in <= 1'b1;
			repeat (4) @(posedge clk);
			forward_step_in <= 1'b0;
			if (!one) reverse_step_in <= 1'b0;
			// Period shortened for run time; origin flag is read only once the train stops
			repeat (3) @(posedge clk);
		end
	endtask : send
endmodule : smp_ctl_model
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb
	import smp_pkg::*;
;
	typedef struct {logic [3:0] bank; logic [3:0] rot; logic cs; int n; logic rev;} smp_row_t;
	smp_row_t rows [7] = '{'{4'h0, 4'h0, 1'b0, 10, 1'b0}, '{4'h0, 4'h1, 1'b0, 3, 1'b0},
		'{4'h0, 4'h1, 1'b1, 3, 1'b1}, '{4'h2, 4'h3, 1'b0, 2, 1'b1}, '{4'h1, 4'hF, 1'b0, 5, 1'b0},
		'{4'h6, 4'h0, 1'b0, 4, 1'b0}, '{4'h8, 4'h2, 1'b0, 1, 1'b0}};
	logic clk = 1'b0, nrst = 1'b0, winding_off_in = 1'b0, free_run_in = 1'b0, fault_clear_in = 1'b0;
	logic step_size_in = 1'b0, fault_event_in = 1'b0, fault_fatal_in = 1'b0, brake_fitted = 1'b1;
	logic [3:0] function_switch_bank = 4'h0, rotary_step_switch = 4'h0;
	logic forward_step_in, reverse_step_in, motor_step, motor_dir, current_on, brake_release;
	logic phase_origin_out, fault_out, fault_led, ready_out, l;
	logic [SMP_POS_W-1:0] position, stat, ang;
	int error_cnt = 0, tests_run = 0, d, base, step_cnt = 0;
	assign stat = {18'h0, fault_out, current_on, ready_out, brake_release};
	smp_step_io #(.BLINK_CYC(8), .SMOOTH_CYC(4)) u_dut(.*);
	smp_ctl_model u_ctl(.*);
	always #20 clk = ~clk;
	always @(posedge clk) begin
		if (motor_step === 1'b1) step_cnt <= step_cnt + 1;
	end
	task automatic chk(input logic [SMP_POS_W-1:0] seen, input logic [SMP_POS_W-1:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic stop_test();
		if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : stop_test
	task automatic do_reset(input logic [3:0] b, input logic [3:0] r);
		function_switch_bank <= b;
		rotary_step_switch <= r;
		nrst <= 1'b0;
		repeat (8) @(posedge clk);
		chk(stat, 22'h8);
		chk(position, SMP_POS_ZERO);
		nrst <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : do_reset
	task automatic wait_chk(input logic [SMP_POS_W-1:0] exp);
		repeat (6) @(posedge clk);
		chk(stat, exp);
	endtask : wait_chk
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		stop_test();
	end
	initial begin
		foreach (rows[i]) begin
			step_size_in <= rows[i].cs;
			do_reset(rows[i].bank, rows[i].rot);
			base = step_cnt;
			u_ctl.send(rows[i].n, rows[i].rev, rows[i].bank[SMP_SW_FORMAT], 1'b1);
			repeat (8) @(posedge clk);
			ang = rows[i].cs ? SMP_BASE_STEP : rows[i].bank[SMP_SW_RANGE] ? SMP_STEP_TWO[rows[i].rot] : SMP_STEP_ONE[rows[i].rot];
			d = (rows[i].n * ang) % SMP_ORIGIN_PITCH;
			if (rows[i].rev && d != 0) d = SMP_ORIGIN_PITCH - d;
			chk(position, d[SMP_POS_W-1:0]);
			chk(SMP_POS_W'(phase_origin_out), SMP_POS_W'(d == 0));
			chk(SMP_POS_W'(motor_dir), SMP_POS_W'(rows[i].rev));
			chk(SMP_POS_W'(step_cnt - base), SMP_POS_W'(rows[i].n));
		end
		// Switches moved after power-up must not change format or angle
		step_size_in <= 1'b0;
		do_reset(4'h0, 4'h0);
		function_switch_bank <= 4'h3;
		rotary_step_switch <= 4'hF;
		u_ctl.send(1, 1'b1, 1'b0, 1'b1);
		wait_chk(22'hF);
		chk(position, SMP_ORIGIN_PITCH - SMP_BASE_STEP);
		winding_off_in <= 1'b1;
		wait_chk(22'h8);
		u_ctl.send(1, 1'b0, 1'b0, 1'b0);
		repeat (6) @(posedge clk);
		chk(position, SMP_ORIGIN_PITCH - SMP_BASE_STEP);
		winding_off_in <= 1'b0;
		free_run_in <= 1'b1;
		wait_chk(22'h9);
		free_run_in <= 1'b0;
		wait_chk(22'hF);
		fault_event_in <= 1'b1;
		wait_chk(22'h0);
		l = fault_led;
		repeat (8) @(posedge clk);
		chk(SMP_POS_W'(fault_led), SMP_POS_W'(!l));
		fault_clear_in <= 1'b1;
		wait_chk(22'h0);
		fault_event_in <= 1'b0;
		wait_chk(22'h0);
		fault_clear_in <= 1'b0;
		repeat (4) @(posedge clk);
		fault_clear_in <= 1'b1;
		wait_chk(22'hF);
		fault_clear_in <= 1'b0;
		fault_fatal_in <= 1'b1;
		repeat (10) @(posedge clk);
		fault_fatal_in <= 1'b0;
		fault_clear_in <= 1'b1;
		wait_chk(22'h0);
		fault_clear_in <= 1'b0;
		// Power cycle clears the fatal alarm; no brake means ready ignores release
		brake_fitted <= 1'b0;
		do_reset(4'h0, 4'h0);
		chk(stat, 22'hE);
		free_run_in <= 1'b1;
		wait_chk(22'h8);
		free_run_in <= 1'b0;
		brake_fitted <= 1'b1;
		do_reset(4'h0, 4'h0);
		chk(stat, 22'hF);
		stop_test();
	end
endmodule : tb
`default_nettype wire
